// ### core/acrb_cfg.svh
// Register map constants for the converter configuration bank.
// Included by the design modules, not by the package; definitions only.
`ifndef ACRB_CFG_SVH
`define ACRB_CFG_SVH

`define ACRB_OFF_INPUT_GAIN    3'h0
`define ACRB_OFF_RATE_MODE     3'h1
`define ACRB_OFF_RESULT_CHECK  3'h2
`define ACRB_OFF_EXCITATION    3'h3
`define ACRB_OFF_GENERAL_PIN   3'h4
`define ACRB_NUM_REGS          5
`define ACRB_RESET_VALUE       8'h00
`define ACRB_UNMAPPED_VALUE    8'h00

`define ACRB_SEL_MSB           7
`define ACRB_SEL_LSB           4
`define ACRB_GAIN_MSB          3
`define ACRB_GAIN_LSB          1
`define ACRB_BYPASS_BIT        0
`define ACRB_NEW_RESULT_BIT    7
`define ACRB_EXC_ZERO_BIT      1
`define ACRB_PIN_ZERO_BIT      7

`define ACRB_RW_MASK_0         8'hff
`define ACRB_RW_MASK_1         8'hff
`define ACRB_RW_MASK_2         8'h7f
`define ACRB_RW_MASK_3         8'hfd
`define ACRB_RW_MASK_4         8'h7f

`define ACRB_GAIN_MAX_BYPASS   3'h2

`endif

// ### core/acrb_pkg.sv
// Types for the converter configuration bank.
// Constants live in acrb_cfg.svh.
package acrb_pkg;

	typedef enum logic [1:0] {
		ACRB_PAIR_DIFF,
		ACRB_PAIR_SINGLE,
		ACRB_PAIR_MONITOR,
		ACRB_PAIR_SHORT
	} acrb_route_type;

	typedef enum logic [1:0] {
		ACRB_ST_IDLE,
		ACRB_ST_WRITE,
		ACRB_ST_READ
	} acrb_state_type;

endpackage

// ### core/acrb_cfg_reg.sv
// One 8-bit configuration register with a write mask.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
`include "acrb_cfg.svh"

module acrb_cfg_reg #(
	parameter logic [7:0] RW_MASK = 8'hff
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Write port
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	// Stored value
	output logic      [7:0] value
);

	logic [7:0] value_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			value_reg <= `ACRB_RESET_VALUE;
		end else if (wr_en) begin
			value_reg <= wr_data & RW_MASK;
		end
	end

	assign value = value_reg;

endmodule

// ### core/acrb_route_decode.sv
// Decodes input select, gain and bypass into analog control lines.
// Pure combinational; the caller registers the results.
`timescale 1ns/1ps
`include "acrb_cfg.svh"

module acrb_route_decode (
	// Register 0 fields
	input  wire logic                  [3:0] input_select,
	input  wire logic                  [2:0] gain_code,
	input  wire logic                        amplifier_bypass,
	// Decoded controls
	output acrb_pkg::acrb_route_type         route,
	output logic                       [1:0] pos_input,
	output logic                       [1:0] neg_input,
	output logic                             amp_enable,
	output logic                             cap_gain_used,
	output logic                             select_reserved
);

	always_comb begin
		route           = acrb_pkg::ACRB_PAIR_DIFF;
		pos_input       = 2'h0;
		neg_input       = 2'h1;
		select_reserved = 1'b0;
		case (input_select)
			4'h0: begin pos_input = 2'h0; neg_input = 2'h1; end
			4'h1: begin pos_input = 2'h0; neg_input = 2'h2; end
			4'h2: begin pos_input = 2'h0; neg_input = 2'h3; end
			4'h3: begin pos_input = 2'h1; neg_input = 2'h0; end
			4'h4: begin pos_input = 2'h1; neg_input = 2'h2; end
			4'h5: begin pos_input = 2'h1; neg_input = 2'h3; end
			4'h6: begin pos_input = 2'h2; neg_input = 2'h3; end
			4'h7: begin pos_input = 2'h3; neg_input = 2'h2; end
			4'h8, 4'h9, 4'ha, 4'hb: begin
				// Negative side goes to the analog negative supply
				route     = acrb_pkg::ACRB_PAIR_SINGLE;
				pos_input = input_select[1:0];
				neg_input = 2'h0;
			end
			4'hc, 4'hd: begin
				route     = acrb_pkg::ACRB_PAIR_MONITOR;
				pos_input = {1'b0, input_select[0]};
				neg_input = 2'h0;
			end
			4'he: begin
				route = acrb_pkg::ACRB_PAIR_SHORT;
			end
			default: begin
				// Reserved code: mid-supply short keeps the inputs safe
				route           = acrb_pkg::ACRB_PAIR_SHORT;
				select_reserved = 1'b1;
			end
		endcase
	end

	always_comb begin
		// High gains force the amplifier on; monitors always bypass it
		if (route == acrb_pkg::ACRB_PAIR_MONITOR) begin
			amp_enable = 1'b0;
		end else if (gain_code > `ACRB_GAIN_MAX_BYPASS) begin
			amp_enable = 1'b1;
		end else begin
			amp_enable = ~amplifier_bypass;
		end
		cap_gain_used = ~amp_enable;
	end

endmodule

// ### core/acrb_bank.sv
// Configuration register bank of a delta-sigma converter.
// Assumes a command decoder on ref_clk delivers one-cycle read/write strobes.
//
// Summary of operation
// - Five 8-bit registers, read and written by register commands.
// - Reset loads every register with zero.
// - Power-down mode leaves register contents unchanged.
// - Input select codes 0000-0111 choose the eight differential pairs.
// - Codes 1000-1011 choose one input against the negative supply.
// - Code 1110 shorts inputs to mid-supply; 1111 is reserved.
// - Gain field bits 3:1 select gains 1 to 128.
// - Bypassed amplifier still gives gains 1, 2, 4 by capacitor stage.
// - Bit 0 of register 0 bypasses the amplifier when set.
// - Gains 8 to 128 keep the amplifier on regardless of bypass, except with monitor codes 1100-1101.
// - Reading a nonexistent register returns zero.
// - Writes to registers other than 4 reset filter, restart conversion.
// - New-result flag is read-only, set on result, cleared on data read.
`timescale 1ns/1ps
`include "acrb_cfg.svh"

module acrb_bank (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Register command port
	input  wire logic       read_register_command,
	input  wire logic       write_register_command,
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] wr_data,
	// Conversion status
	input  wire logic       result_ready,
	input  wire logic       data_read,
	input  wire logic       power_down,
	// Read answer
	output logic            rd_valid,
	output logic      [7:0] rd_data,
	// Converter control
	output logic            filter_restart,
	output logic            new_result_flag,
	output logic      [3:0] input_select,
	output logic      [2:0] gain_code,
	output logic            amplifier_bypass,
	output logic            amp_enable,
	output logic            cap_gain_used,
	output logic      [1:0] pos_input,
	output logic      [1:0] neg_input,
	output acrb_pkg::acrb_route_type route,
	output logic            select_reserved,
	output logic      [7:0] rate_mode_config,
	output logic      [6:0] result_check_ctrl,
	output logic      [7:0] excitation_route_config,
	output logic      [6:0] general_pin_config,
	output logic            pin2_direction
);

	logic [7:0] reg_value [0:`ACRB_NUM_REGS-1];
	logic [`ACRB_NUM_REGS-1:0] wr_sel;
	logic       new_result_reg;
	logic       rd_valid_reg;
	logic [7:0] rd_data_reg;
	logic       restart_reg;
	logic [7:0] read_mux;
	logic                     dec_amp_enable;
	logic                     dec_cap_gain;
	logic [1:0]               dec_pos;
	logic [1:0]               dec_neg;
	acrb_pkg::acrb_route_type dec_route;
	logic                     dec_reserved;
	logic                     amp_enable_reg;
	logic                     cap_gain_reg;
	logic [1:0]               pos_reg;
	logic [1:0]               neg_reg;
	acrb_pkg::acrb_route_type route_reg;
	logic                     reserved_reg;

	localparam logic [7:0] RW_MASKS [0:`ACRB_NUM_REGS-1] = '{
		`ACRB_RW_MASK_0, `ACRB_RW_MASK_1, `ACRB_RW_MASK_2, `ACRB_RW_MASK_3, `ACRB_RW_MASK_4
	};

	// Power-down stops the analog side only; writes from the host still land
	// and nothing here clears the bank, so contents are held across it.
	genvar gi;
	generate
		for (gi = 0; gi < `ACRB_NUM_REGS; gi++) begin : g_reg
			assign wr_sel[gi] = write_register_command && (reg_addr == 3'(gi));
			acrb_cfg_reg #(
				.RW_MASK (RW_MASKS[gi])
			) u_reg (
				.ref_clk (ref_clk),
				.rst     (rst),
				.wr_en   (wr_sel[gi]),
				.wr_data (wr_data),
				.value   (reg_value[gi])
			);
		end
	endgenerate

	// Set wins over clear so a result landing during a read is not lost
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			new_result_reg <= 1'b0;
		end else if (result_ready) begin
			new_result_reg <= 1'b1;
		end else if (data_read) begin
			new_result_reg <= 1'b0;
		end
	end

	always_comb begin
		case (reg_addr)
			`ACRB_OFF_INPUT_GAIN:   read_mux = reg_value[0];
			`ACRB_OFF_RATE_MODE:    read_mux = reg_value[1];
			`ACRB_OFF_RESULT_CHECK: read_mux = {new_result_reg, reg_value[2][6:0]};
			`ACRB_OFF_EXCITATION:   read_mux = reg_value[3];
			`ACRB_OFF_GENERAL_PIN:  read_mux = reg_value[4];
			default:                read_mux = `ACRB_UNMAPPED_VALUE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_valid_reg <= 1'b0;
			rd_data_reg  <= 8'h00;
		end else begin
			rd_valid_reg <= read_register_command;
			if (read_register_command) begin
				rd_data_reg <= read_mux;
			end
		end
	end

	// General pin register writes leave the filter running
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= |wr_sel[`ACRB_NUM_REGS-2:0];
		end
	end

	acrb_route_decode u_decode (
		.input_select     (reg_value[0][`ACRB_SEL_MSB:`ACRB_SEL_LSB]),
		.gain_code        (reg_value[0][`ACRB_GAIN_MSB:`ACRB_GAIN_LSB]),
		.amplifier_bypass (reg_value[0][`ACRB_BYPASS_BIT]),
		.route            (dec_route),
		.pos_input        (dec_pos),
		.neg_input        (dec_neg),
		.amp_enable       (dec_amp_enable),
		.cap_gain_used    (dec_cap_gain),
		.select_reserved  (dec_reserved)
	);

	// Decoded controls registered so every output comes from a flip-flop
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			amp_enable_reg <= 1'b1;
			cap_gain_reg   <= 1'b0;
			pos_reg        <= 2'h0;
			neg_reg        <= 2'h1;
			route_reg      <= acrb_pkg::ACRB_PAIR_DIFF;
			reserved_reg   <= 1'b0;
		end else begin
			amp_enable_reg <= dec_amp_enable;
			cap_gain_reg   <= dec_cap_gain;
			pos_reg        <= dec_pos;
			neg_reg        <= dec_neg;
			route_reg      <= dec_route;
			reserved_reg   <= dec_reserved;
		end
	end

	assign rd_valid                = rd_valid_reg;
	assign rd_data                 = rd_data_reg;
	assign filter_restart          = restart_reg;
	assign new_result_flag         = new_result_reg;
	assign input_select            = reg_value[0][`ACRB_SEL_MSB:`ACRB_SEL_LSB];
	assign gain_code               = reg_value[0][`ACRB_GAIN_MSB:`ACRB_GAIN_LSB];
	assign amplifier_bypass        = reg_value[0][`ACRB_BYPASS_BIT];
	assign amp_enable              = amp_enable_reg;
	assign cap_gain_used           = cap_gain_reg;
	assign pos_input               = pos_reg;
	assign neg_input               = neg_reg;
	assign route                   = route_reg;
	assign select_reserved         = reserved_reg;
	assign rate_mode_config        = reg_value[1];
	assign result_check_ctrl       = reg_value[2][6:0];
	assign excitation_route_config = reg_value[3];
	assign general_pin_config      = reg_value[4][6:0];
	assign pin2_direction          = reg_value[4][6];

endmodule

// ### testbench/acrb_bank_monitor.sv
// Port checker for acrb_bank.
// Assumes one clock, synchronous reset.
`timescale 1ns/1ps
module acrb_bank_monitor (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst,
	// Commands and status
	input wire logic       read_register_command,
	input wire logic       write_register_command,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic       result_ready,
	input wire logic       data_read,
	input wire logic       power_down,
	// Answers
	input wire logic       rd_valid,
	input wire logic [7:0] rd_data,
	input wire logic       filter_restart,
	input wire logic       new_result_flag,
	input wire logic [3:0] input_select,
	input wire logic [2:0] gain_code,
	input wire logic       amplifier_bypass,
	input wire logic       amp_enable,
	input wire logic [7:0] rate_mode_config,
	input wire logic [7:0] excitation_route_config
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic wr0;
	logic wlo;
	assign wr0 = write_register_command && reg_addr == 3'h0;
	assign wlo = write_register_command && reg_addr < 3'h4;
	read_answer_a: assert property (read_register_command |=> rd_valid) else $error("rd_valid");
	answer_only_a: assert property (!read_register_command |=> !rd_valid) else $error("rd_valid");
	unmapped_zero_a: assert property (read_register_command && reg_addr > 3'h4 |=> rd_data == 8'h00)
		else $error("unmapped");
	restart_a: assert property (wlo |=> filter_restart) else $error("restart");
	no_restart_a: assert property (!wlo |=> !filter_restart) else $error("restart");
	flag_set_a: assert property (result_ready |=> new_result_flag) else $error("flag");
	flag_clear_a: assert property (data_read && !result_ready |=> !new_result_flag) else $error("flag");
	reg0_write_a: assert property (wr0 |=> {input_select, gain_code, amplifier_bypass} == $past(wr_data))
		else $error("reg0");
	high_gain_a: assert property (wr0 && wr_data[3:1] > 3'h2 && wr_data[7:5] != 3'h6 ##1 !wr0 |=> amp_enable)
		else $error("amp");
	fixed_zero_a: assert property (!excitation_route_config[1]) else $error("bit1");
	power_hold_a: assert property (power_down && !write_register_command |=> $stable(rate_mode_config))
		else $error("hold");
	reset_zero_a: assert property (disable iff (1'b0) rst |=> rate_mode_config == 8'h00 && gain_code == 3'h0)
		else $error("reset");
	cover property (wr0);
	cover property (read_register_command && reg_addr > 3'h4);
	cover property (result_ready && data_read);
endmodule

bind acrb_bank acrb_bank_monitor acrb_bank_monitor_i (.ref_clk, .rst, .read_register_command,
	.write_register_command, .reg_addr, .wr_data, .result_ready, .data_read, .power_down, .rd_valid,
	.rd_data, .filter_restart, .new_result_flag, .input_select, .gain_code, .amplifier_bypass,
	.amp_enable, .rate_mode_config, .excitation_route_config);

// ### testbench/acrb_host_model.sv
// Host model issuing register commands.
// Drives 1 ns after the rising edge; released lines show inverted values.
`timescale 1ns/1ps
module acrb_host_model (
	// Clock
	input wire logic       ref_clk,
	// Command side
	output logic           read_register_command = 1'b0,
	output logic           write_register_command = 1'b0,
	output logic     [2:0] reg_addr = 3'h0,
	output logic     [7:0] wr_data = 8'h00,
	// Answer side
	input wire logic       rd_valid,
	input wire logic [7:0] rd_data,
	input wire logic       filter_restart
);
	task automatic wr(input logic [2:0] a, input logic [7:0] d, output logic rs);
		if (a == 3'h0 && d[7:6] == 2'b10)
			d[3:0] = 4'h1; // Negative input on supply: bypass, gain 1
		@(posedge ref_clk);
		#1;
		write_register_command = 1'b1;
		reg_addr = a;
		wr_data = d;
		@(posedge ref_clk);
		#1;
		write_register_command = 1'b0;
		wr_data = ~d;
		rs = filter_restart;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic v);
		@(posedge ref_clk);
		#1;
		read_register_command = 1'b1;
		reg_addr = a;
		@(posedge ref_clk);
		#1;
		read_register_command = 1'b0;
		reg_addr = ~a;
		d = rd_data;
		v = rd_valid;
	endtask
endmodule

// ### testbench/acrb_bank_tb.sv
// Testbench for acrb_bank.
// Host model drives commands; status inputs driven here.
`timescale 1ns/1ps
module acrb_bank_tb;
	logic ref_clk, rst, read_register_command, write_register_command, result_ready, data_read, power_down;
	logic rd_valid, filter_restart, new_result_flag, amplifier_bypass, amp_enable, cap_gain_used;
	logic select_reserved, pin2_direction, v, rs;
	logic [1:0] pos_input, neg_input;
	logic [2:0] reg_addr, gain_code;
	logic [3:0] input_select;
	logic [6:0] result_check_ctrl, general_pin_config;
	logic [7:0] wr_data, rd_data, rate_mode_config, excitation_route_config, d;
	acrb_pkg::acrb_route_type route;
	int n_errors = 0, comparisons = 0, cyc = 0;
	acrb_bank acrb_bank_i (.*);
	acrb_host_model acrb_host_model_i (.ref_clk, .read_register_command, .write_register_command,
		.reg_addr, .wr_data, .rd_valid, .rd_data, .filter_restart);
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_rw();
		logic [7:0] m [6] = '{8'hff, 8'hff, 8'h7f, 8'hfd, 8'h7f, 8'h00};
		for (int i = 0; i < 8; i++) begin
			acrb_host_model_i.rd(i[2:0], d, v);
			chk("reset value", 8'h00, d);
		end
		for (int i = 0; i < 6; i++) begin
			acrb_host_model_i.wr(i[2:0], 8'hff, rs);
			chk("restart", {7'h0, i < 4}, {7'h0, rs});
			acrb_host_model_i.rd(i[2:0], d, v);
			chk("readback", m[i], d);
			chk("rd_valid", 8'h01, {7'h0, v});
		end
		chk("pin2", 8'h01, {7'h0, pin2_direction});
		chk("rate", 8'hff, rate_mode_config);
		chk("check ctrl", 8'h7f, {1'b0, result_check_ctrl});
		chk("excitation", 8'hfd, excitation_route_config);
		chk("pin config", 8'h7f, {1'b0, general_pin_config});
		$display("done rw");
	endtask
	task automatic t_decode();
		logic [1:0] pp [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3};
		logic [1:0] nn [8] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h3, 2'h2};
		for (int s = 0; s < 16; s++) begin
			acrb_host_model_i.wr(3'h0, {s[3:0], 4'h1}, rs);
			@(posedge ref_clk);
			#1;
			chk("select", {4'h0, s[3:0]}, {4'h0, input_select});
			chk("route", (s < 8) ? 8'h0 : (s < 12) ? 8'h1 : (s < 14) ? 8'h2 : 8'h3, {6'h0, route});
			chk("reserved", {7'h0, s == 15}, {7'h0, select_reserved});
			if (s < 8) begin
				chk("pos", {6'h0, pp[s]}, {6'h0, pos_input});
				chk("neg", {6'h0, nn[s]}, {6'h0, neg_input});
			end else if (s < 12) begin
				chk("pos", {6'h0, s[1:0]}, {6'h0, pos_input});
			end
		end
		for (int g = 0; g < 8; g++) begin
			acrb_host_model_i.wr(3'h0, {4'h0, g[2:0], 1'b1}, rs);
			@(posedge ref_clk);
			#1;
			chk("gain", {5'h0, g[2:0]}, {5'h0, gain_code});
			chk("amp", {7'h0, g > 2}, {7'h0, amp_enable});
			chk("capgain", {7'h0, g <= 2}, {7'h0, cap_gain_used});
		end
		acrb_host_model_i.wr(3'h0, 8'h00, rs);
		@(posedge ref_clk);
		#1;
		chk("amp", 8'h01, {7'h0, amp_enable});
		$display("done decode");
	endtask
	task automatic t_flag();
		result_ready = 1'b1;
		@(posedge ref_clk);
		#1;
		result_ready = 1'b0;
		acrb_host_model_i.wr(3'h2, 8'h00, rs);
		acrb_host_model_i.rd(3'h2, d, v);
		chk("flag set", 8'h80, d);
		chk("flag pin", 8'h01, {7'h0, new_result_flag});
		data_read = 1'b1;
		@(posedge ref_clk);
		#1;
		data_read = 1'b0;
		acrb_host_model_i.rd(3'h2, d, v);
		chk("flag clear", 8'h00, d);
		// A result landing in the same cycle as a data read must not be lost
		result_ready = 1'b1;
		data_read = 1'b1;
		@(posedge ref_clk);
		#1;
		result_ready = 1'b0;
		data_read = 1'b0;
		chk("set wins", 8'h01, {7'h0, new_result_flag});
		$display("done flag");
	endtask
	task automatic t_hold();
		acrb_host_model_i.wr(3'h1, 8'h3c, rs);
		power_down = 1'b1;
		repeat (5) @(posedge ref_clk);
		acrb_host_model_i.rd(3'h1, d, v);
		chk("held", 8'h3c, d);
		power_down = 1'b0;
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		acrb_host_model_i.rd(3'h1, d, v);
		chk("rereset", 8'h00, d);
		$display("done hold");
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		rst = 1'b1;
		result_ready = 1'b0;
		data_read = 1'b0;
		power_down = 1'b0;
		repeat (12) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		t_rw();
		t_decode();
		t_flag();
		t_hold();
		tally_and_finish();
	end
endmodule
